// ---- lsp_cache_ctl.sv ----
// Top: cache_control register on Wishbone and the pin-level pipeline control.
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "lsp_defines.svh"
module lsp_cache_ctl (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`LSP_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] hostAddrStrap,
	input wire logic cpu_addr_strobe_n,
	input wire logic burst_ready_n,
	input wire logic lastBurstReady,
	output logic next_address_request_n,
	output logic cache_sram_select_n,
	output logic cache_addr_strobe_n,
	output logic [1:0] l2_sram_type_field,
	output logic [1:0] secondary_cache_size
);
	logic [7:0] cache_control_r;
	logic [7:0] cache_control_nxt;
	logic ack_r;
	logic [31:0] rdata_r;
	logic [3:0] strapInv;
	logic strapValid;
	logic strapValidD_r;
	logic naReq;
	logic sramSelDrop;
	logic cacheStrobe;
	logic pipeMode;
	lsp_pkg::lsp_state_t pipeState;

	////////////////////////////////////////////////////////////////////////
	// Strap capture for the size and type fields.
	lsp_strap_latch u_strap (
		.clk(clk),
		.resetn(resetn),
		.strapAddr(hostAddrStrap),
		.strapInv(strapInv),
		.strapValid(strapValid)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus decode. The slave answers every access one cycle after the
	// request; unmapped reads return zero and unmapped writes are dropped.
	wire busReq = wb_cyc_i && wb_stb_i && !ack_r;
	wire hitCc = (wb_adr_i == `LSP_OFF_CACHE_CONTROL);
	wire hitSt = (wb_adr_i == `LSP_OFF_STATUS);
	wire ccWrite = busReq && wb_we_i && hitCc && wb_sel_i[0];
	wire strapLoad = strapValid && !strapValidD_r;

	// Strap load happens once, at the second clock edge after reset release, and wins over a bus write in the same cycle.
	always_comb begin
		cache_control_nxt = cache_control_r;
		if (strapLoad) begin
			cache_control_nxt[`LSP_SCS_HI:`LSP_TYPE_LO] = strapInv;
		end else if (ccWrite) begin
			cache_control_nxt = wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cache_control_r <= {4'h0, `LSP_CC_LOW_RESET};
			strapValidD_r <= 1'b0;
		end else begin
			cache_control_r <= cache_control_nxt;
			strapValidD_r <= strapValid;
		end
	end

	// Read data and ack are registered.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0;
		end else begin
			ack_r <= busReq;
			if (busReq && !wb_we_i) begin
				rdata_r <= hitCc ? {24'h0, cache_control_r} :
					hitSt ? {29'h0, pipeMode, pipeState} : 32'h0;
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// Field decode; the written value governs from the next cycle on.
	// type encoding
	wire [1:0] sramType = cache_control_r[`LSP_TYPE_HI:`LSP_TYPE_LO];
	wire [1:0] cacheSize = cache_control_r[`LSP_SCS_HI:`LSP_SCS_LO];
	wire nextAddrDisable = cache_control_r[`LSP_NAD_BIT];
	wire typeIsPipelined = (sramType == `LSP_TYPE_ONE_BANK) || (sramType == `LSP_TYPE_TWO_BANK);
	wire sizeValid = (cacheSize == `LSP_SIZE_256K) || (cacheSize == `LSP_SIZE_512K);
	assign pipeMode = typeIsPipelined && (cacheSize == `LSP_SIZE_512K);
	wire naAllowed = !nextAddrDisable && typeIsPipelined && sizeValid && strapValidD_r;

	////////////////////////////////////////////////////////////////////////
	// Pipeline sequencer, active-high inside.
	lsp_pipe_ctl u_pipe (
		.clk(clk),
		.resetn(resetn),
		.naAllowed(naAllowed),
		.pipeMode(pipeMode),
		.cpuAddrStrobe(!cpu_addr_strobe_n),
		.burstReady(!burst_ready_n),
		.lastReady(lastBurstReady),
		.naReq(naReq),
		.sramSelDrop(sramSelDrop),
		.cacheStrobe(cacheStrobe),
		.state(pipeState)
	);

	// Pin drive; chip select goes high when the size field is none or while sramSelDrop is set.
	assign next_address_request_n = !naReq;
	assign cache_sram_select_n = sramSelDrop || (cacheSize == `LSP_SIZE_NONE);
	assign cache_addr_strobe_n = !cacheStrobe;
	assign l2_sram_type_field = sramType;
	assign secondary_cache_size = cacheSize;
endmodule

// ---- lsp_cache_ctl_asserts.sv ----
// Port checker for the cache control block.
`timescale 1ns/1ps
`include "lsp_defines.svh"
module lsp_cache_ctl_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`LSP_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic [3:0] hostAddrStrap,
	input wire logic cpu_addr_strobe_n,
	input wire logic burst_ready_n,
	input wire logic lastBurstReady,
	input wire logic next_address_request_n,
	input wire logic cache_sram_select_n,
	input wire logic cache_addr_strobe_n,
	input wire logic [1:0] l2_sram_type_field,
	input wire logic [1:0] secondary_cache_size
);
	logic nadBit_r;
	logic [1:0] postCnt_r;
	// Accepted register writes, and the mode in which the select is pipelined.
	wire ccWr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
		& (wb_adr_i == `LSP_OFF_CACHE_CONTROL);
	wire pipe512 = secondary_cache_size == `LSP_SIZE_512K
		&& l2_sram_type_field inside {`LSP_TYPE_ONE_BANK, `LSP_TYPE_TWO_BANK};
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// The disable bit is shadowed, since the checker cannot see the register.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			nadBit_r <= 1'b1;
			postCnt_r <= 2'h0;
		end else begin
			if (ccWr)
				nadBit_r <= wb_dat_i[`LSP_NAD_BIT];
			if (postCnt_r != 2'h3)
				postCnt_r <= postCnt_r + 2'h1;
		end
	end
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_field_write: assert property (ccWr |=>
		{secondary_cache_size, l2_sram_type_field} == $past(wb_dat_i[7:4]))
		else $error("fields not written");
	a_strap_load: assert property (postCnt_r == 2'h2 |->
		l2_sram_type_field == ~$past(hostAddrStrap[1:0], 2)
		&& secondary_cache_size == ~$past(hostAddrStrap[3:2], 2)) else $error("strap");
	a_nad_blocks: assert property (nadBit_r |-> next_address_request_n)
		else $error("next address while disabled");
	a_na_gated: assert property (!next_address_request_n |->
		secondary_cache_size inside {2'h1, 2'h2} && l2_sram_type_field inside {2'h0, 2'h3})
		else $error("next address in bad mode");
	a_cache_addr_strobe_n_final: assert property (!cache_addr_strobe_n |->
		!burst_ready_n && lastBurstReady) else $error("cache strobe on non-final ready");
	a_sram_deselect: assert property (pipe512 && !next_address_request_n ##1
		cpu_addr_strobe_n |-> cache_sram_select_n) else $error("select not dropped");
	a_sram_reselect: assert property (pipe512 && !cpu_addr_strobe_n |->
		!cache_sram_select_n) else $error("select not restored");
	cover property (!next_address_request_n);
	cover property (!cache_addr_strobe_n);
	cover property (ccWr);
endmodule
bind lsp_cache_ctl lsp_cache_ctl_chk chk_u (.*);

// ---- lsp_defines.svh ----
// Constants for the L2 SRAM type and pipelined next-address control block.
// Behaviour
// - Reset release loads type from inverted address straps.
// - Software writes replace the strap-loaded type.
// - Deselect SRAM after next-address in 512K pipelined mode; reselect on strobe.
// - In 512K pipelined mode, cache strobe with final ready when pipelined pending.
// - Disable bit set blocks next-address request.
// - Otherwise next-address follows type and size.
// - Size 00 none, 01 256K, 10 512K.
`ifndef LSP_DEFINES_SVH
`define LSP_DEFINES_SVH

// Register map, byte addresses on the Wishbone slave.
`define LSP_ADDR_W 4
`define LSP_OFF_CACHE_CONTROL 4'h0
`define LSP_OFF_STATUS 4'h4

// Field positions in cache_control.
`define LSP_SCS_HI 7
`define LSP_SCS_LO 6
`define LSP_TYPE_HI 5
`define LSP_TYPE_LO 4
`define LSP_NAD_BIT 3
`define LSP_LOW_HI 2

// Reset value of the non-strap bits (next_addr_disable set, low bits 010).
`define LSP_CC_LOW_RESET 4'hA

// Encodings of the two fields.
`define LSP_TYPE_ONE_BANK 2'h0
`define LSP_TYPE_TWO_BANK 2'h3
`define LSP_SIZE_NONE 2'h0
`define LSP_SIZE_256K 2'h1
`define LSP_SIZE_512K 2'h2

`endif

// ---- lsp_host_model.sv ----
// Host bus model: four-beat bursts, pipelined one cycle late on next-address.
`timescale 1ns/1ps
module lsp_host_model (
	input wire logic clk,
	input wire logic go,
	input wire logic stall,
	input wire logic next_address_request_n,
	output logic cpu_addr_strobe_n,
	output logic burst_ready_n,
	output logic lastBurstReady
);
	int beat = 0;
	int pend = 0;
	// Idle strobe and ready lines return high, as the pull-ups would take them; lastBurstReady returns low.
	always @(posedge clk) begin
		cpu_addr_strobe_n <= 1'b1;
		burst_ready_n <= 1'b1;
		lastBurstReady <= 1'b0;
		if (beat == 0 && go) begin
			cpu_addr_strobe_n <= 1'b0;
			beat <= 1;
		end else if (beat > 0 && !stall) begin
			burst_ready_n <= 1'b0;
			lastBurstReady <= beat == 4;
			beat <= beat == 4 ? (pend == 2 ? 1 : 0) : beat + 1;
		end
		if (pend == 1) begin
			cpu_addr_strobe_n <= 1'b0;
			pend <= 2;
		end
		if (!next_address_request_n && go && pend == 0)
			pend <= 1;
		if (beat == 4 && !stall && pend == 2)
			pend <= 0;
	end
endmodule

// ---- lsp_pipe_ctl.sv ----
// Pipelined burst sequencer: next-address, SRAM select and cache strobe.
`timescale 1ns/1ps
`include "lsp_defines.svh"
module lsp_pipe_ctl (
	input wire logic clk,
	input wire logic resetn,
	input wire logic naAllowed,
	input wire logic pipeMode,
	input wire logic cpuAddrStrobe,
	input wire logic burstReady,
	input wire logic lastReady,
	output logic naReq,
	output logic sramSelDrop,
	output logic cacheStrobe,
	output lsp_pkg::lsp_state_t state
);
	lsp_pkg::lsp_state_t state_r;
	lsp_pkg::lsp_state_t state_nxt;

	////////////////////////////////////////////////////////////////////////
	// A cycle opens on a strobe; next-address goes out on the first ready
	// of the burst, and a second strobe in that window is the pipelined one.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			lsp_pkg::LSP_IDLE: begin
				if (cpuAddrStrobe) begin
					state_nxt = lsp_pkg::LSP_BURST;
				end
			end
			lsp_pkg::LSP_BURST: begin
				if (burstReady && lastReady) begin
					state_nxt = lsp_pkg::LSP_IDLE;
				end else if (burstReady && naAllowed) begin
					state_nxt = lsp_pkg::LSP_NA_SENT;
				end
			end
			lsp_pkg::LSP_NA_SENT: begin
				if (cpuAddrStrobe && burstReady && lastReady) begin
					state_nxt = lsp_pkg::LSP_BURST;
				end else if (cpuAddrStrobe) begin
					state_nxt = lsp_pkg::LSP_PIPE_PEND;
				end else if (burstReady && lastReady) begin
					state_nxt = lsp_pkg::LSP_IDLE;
				end
			end
			lsp_pkg::LSP_PIPE_PEND: begin
				if (burstReady && lastReady) begin
					state_nxt = lsp_pkg::LSP_BURST;
				end
			end
			default: state_nxt = lsp_pkg::LSP_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= lsp_pkg::LSP_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// allowed next-address
	assign naReq = (state_r == lsp_pkg::LSP_BURST) && burstReady && !lastReady && naAllowed;
	assign sramSelDrop = pipeMode && (state_r == lsp_pkg::LSP_NA_SENT) && !cpuAddrStrobe;
	assign cacheStrobe = pipeMode && burstReady && lastReady &&
		((state_r == lsp_pkg::LSP_PIPE_PEND) ||
		((state_r == lsp_pkg::LSP_NA_SENT) && cpuAddrStrobe));
	assign state = state_r;
endmodule

// ---- lsp_pkg.sv ----
// Types shared by the L2 SRAM type and pipeline control block.
package lsp_pkg;
	typedef enum logic [1:0] {
		LSP_IDLE = 2'b00,
		LSP_BURST = 2'b01,
		LSP_NA_SENT = 2'b10,
		LSP_PIPE_PEND = 2'b11
	} lsp_state_t;
endpackage

// ---- lsp_strap_latch.sv ----
// Catches the strap levels once, on the first clock after reset release.
`timescale 1ns/1ps
`include "lsp_defines.svh"
module lsp_strap_latch (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] strapAddr,
	output logic [3:0] strapInv,
	output logic strapValid
);
	logic captured_r;
	logic [3:0] value_r;

	////////////////////////////////////////////////////////////////////////
	// Asynchronous reset may only load constants, so the strap is taken
	// by the first clock edge after the release.
	// inverted strap capture
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			captured_r <= 1'b0;
			value_r <= 4'h0;
		end else if (!captured_r) begin
			captured_r <= 1'b1;
			value_r <= ~strapAddr;
		end
	end

	assign strapInv = value_r;
	assign strapValid = captured_r;
endmodule

// ---- test_l2_sram_type_and_pipeline_ctl.sv ----
// Self-checking bench for the cache control block.
`timescale 1ns/1ps
`include "lsp_defines.svh"
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin n_mismatch++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module test_l2_sram_type_and_pipeline_ctl;
	logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
	logic stall = 1'b0, ack, naN, selN, cadsN, cpuN, rdyN, last, exp, m512;
	logic [3:0] adr = 4'h0, sel = 4'h0, strap = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q, seed = 32'h2F15;
	logic [1:0] typeF, sizeF;
	logic [4:0] cfg [6] = '{5'h10, 5'h16, 5'h17, 5'h00, 5'h12, 5'h08};
	int n_mismatch = 0, compares = 0, ticks = 0, naCnt, cadsCnt, cc, selCnt, dropCnt;
	always #4 clk = ~clk;
	lsp_cache_ctl dut_u (.clk, .resetn, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.hostAddrStrap(strap), .cpu_addr_strobe_n(cpuN), .burst_ready_n(rdyN),
		.lastBurstReady(last), .next_address_request_n(naN), .cache_sram_select_n(selN),
		.cache_addr_strobe_n(cadsN), .l2_sram_type_field(typeF), .secondary_cache_size(sizeF));
	lsp_host_model host_u (.clk, .go, .stall, .next_address_request_n(naN),
		.cpu_addr_strobe_n(cpuN), .burst_ready_n(rdyN), .lastBurstReady(last));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task give_verdict();
		if (n_mismatch == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One classic cycle; read data is taken at the edge that samples ack.
	task bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, s, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb, we} <= 3'h0;
	endtask
	// Pin activity counters and the hang limit.
	always @(posedge clk) begin
		ticks++;
		naCnt += !naN;
		cadsCnt += !cadsN;
		selCnt += !selN;
		dropCnt += selN;
		if (ticks == 2000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		void'(rnd());
		strap = seed[3:0];
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("type", ~strap[1:0], typeF)
		`CHK("size", ~strap[3:2], sizeF)
		cc = {~strap, `LSP_CC_LOW_RESET};
		bus(1'b0, 4'h0, 4'h1, 32'h0);
		`CHK("cc", cc, q)
		repeat (4) begin
			void'(rnd());
			cc = seed[7:0];
			bus(1'b1, 4'h0, 4'h1, seed);
			bus(1'b0, 4'h0, 4'h1, 32'h0);
			`CHK("cc", cc, q)
			`CHK("type", cc[5:4], typeF)
		end
		bus(1'b1, 4'h0, 4'h0, 32'hFF);
		bus(1'b0, 4'h8, 4'h1, 32'h0);
		`CHK("unmapped", 32'h0, q)
		bus(1'b0, 4'h0, 4'h1, 32'h0);
		`CHK("cc", cc, q)
		// Disable bit set or cleared per wiring case.
		// Sizes 256K and 512K allow next-address; only 512K runs the pipelined select.
		for (int i = 0; i < 6; i++) begin
			cc = {cfg[i], 3'h2};
			exp = cc[7:6] inside {2'h1, 2'h2} && !cc[3] && cc[5:4] inside {2'h0, 2'h3};
			m512 = cc[7:6] == 2'h2 && cc[5:4] inside {2'h0, 2'h3};
			bus(1'b1, 4'h0, 4'h1, cc);
			bus(1'b0, `LSP_OFF_STATUS, 4'h1, 32'h0);
			`CHK("mode", m512 ? 3'h4 : 3'h0, q[2:0])
			naCnt = 0;
			cadsCnt = 0;
			selCnt = 0;
			dropCnt = 0;
			go <= 1'b1;
			repeat (40) begin
				@(posedge clk);
				stall <= rnd() > 32'hC0000000;
			end
			{go, stall} <= 2'h0;
			repeat (12) @(posedge clk);
			`CHK("na", exp, naCnt > 0)
			`CHK("cache_addr_strobe_n", m512 && exp, cadsCnt > 0)
			`CHK("sel", cc[7:6] != 2'h0, selCnt > 0)
			`CHK("drop", (m512 && exp) || cc[7:6] == 2'h0, dropCnt > 0)
		end
		give_verdict();
	end
endmodule
